// ---- shared/wb_dither_consts.vh ----
// constants for the white balance and dither pixel block
`ifndef WB_DITHER_CONSTS_VH
`define WB_DITHER_CONSTS_VH
// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_TIMING 12'h004
`define OFS_PAGE 12'h008
`define OFS_LUT_ADDR 12'h00C
`define OFS_LUT_DATA 12'h010
`define OFS_STATUS 12'h014
// control field positions
`define CTRL_WB_EN 0
`define CTRL_RELOAD_EN 1
`define CTRL_PRE_EN 2
`define CTRL_POST_EN 3
// timing field positions
`define TIM_DE_ONLY 0
`define TIM_HS_POL 1
`define TIM_VS_POL 2
`define TIM_DE_POL 3
// reset values
`define CTRL_RST 4'h0
`define TIMING_RST 4'h8
// page codes
`define PAGE_RED 2'h0
`define PAGE_GREEN 2'h1
`define PAGE_BLUE 2'h2
// frames without vsync: blank run threshold in pixel clocks
`define DE_ONLY_BLANK 12'h800
`endif

// ---- tb/video_src.sv ----
// upstream video source: 4 lines of 8 pixels per frame, active high syncs
`timescale 1ns/1ps
module video_src (
   input wire clk_sys_i,
   input wire resetn_i,
   input wire [23:0] pix_i,
   output reg [23:0] rgb_o,
   output reg hs_o,
   output reg vs_o,
   output reg de_o
);
   reg [3:0] pcnt_ff; // clock within a line, 12 per line
   reg [2:0] lcnt_ff; // line within a frame, line 4 is vertical blank
   wire act = (lcnt_ff != 3'h4) && (pcnt_ff < 4'h8); // active pixel slot
   // one frame holds exactly one 4 line by 8 pixel dither period
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         pcnt_ff <= 4'h0;
         lcnt_ff <= 3'h0;
         rgb_o <= 24'h0;
         {hs_o, vs_o, de_o} <= 3'h0;
      end else begin
         pcnt_ff <= (pcnt_ff == 4'hB) ? 4'h0 : pcnt_ff + 4'h1;
         if (pcnt_ff == 4'hB) begin
            lcnt_ff <= (lcnt_ff == 3'h4) ? 3'h0 : lcnt_ff + 3'h1;
         end
         de_o <= act;
         hs_o <= (pcnt_ff == 4'h9);
         vs_o <= (lcnt_ff == 3'h4);
         // blank data toggles every clock, starting from the inverse of the last pixel, so stale values rarely pass as fresh
         rgb_o <= act ? pix_i : ~rgb_o;
      end
   end
endmodule // video_src

// ---- tb/wb_dither_top_assertions.sv ----
// port level checks for the white balance and dither block
`timescale 1ns/1ps
`include "wb_dither_consts.vh"
module wb_dither_top_assertions (
   input wire clk_sys_i,
   input wire resetn_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   input wire [23:0] rgb_i,
   input wire hs_i,
   input wire vs_i,
   input wire de_i,
   input wire [23:0] rgb_o,
   input wire hs_o,
   input wire vs_o,
   input wire de_o
);
   reg [3:0] ctrl_ff; // shadow of the control register
   reg seen_ff; // white balance was on once since reset
   wire acc = psel_i && penable_i; // access phase
   wire rd = acc && !pwrite_i; // read access phase
   wire unm = (paddr_i > `OFS_STATUS) || (paddr_i[1:0] != 2'b00); // no register at this address
   // follow control writes so mode dependent checks know the stage setup
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         ctrl_ff <= 4'h0;
         seen_ff <= 1'b0;
      end else begin
         if (acc && pwrite_i && paddr_i == `OFS_CTRL) begin
            ctrl_ff <= pwdata_i[3:0];
         end
         if (ctrl_ff[0]) begin
            seen_ff <= 1'b1;
         end
      end
   end
   // dithered value may sit one step above the truncated input, never below
   function ok6(input [7:0] o, input [7:0] i);
      ok6 = ({1'b0, o[7:2]} - {1'b0, i[7:2]}) <= 7'h01;
   endfunction
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   a_ready_zero_wait:
   assert property (acc |-> pready_o) else $error("access phase without ready");
   a_unmapped_err:
   assert property (acc |-> pslverr_o == unm) else $error("error response wrong");
   a_unmapped_zero:
   assert property (rd && unm |-> prdata_o == 32'h0) else $error("unmapped read not zero");
   a_ctrl_readback:
   assert property (rd && paddr_i == `OFS_CTRL |-> prdata_o == {28'h0, ctrl_ff}) else $error("control readback");
   a_lock_status:
   assert property (rd && paddr_i == `OFS_STATUS && $stable(ctrl_ff) && $stable(seen_ff)
      |-> prdata_o[4] == (seen_ff && !ctrl_ff[1])) else $error("lock flag wrong");
   a_sync_delay:
   assert property ({hs_o, vs_o, de_o} == $past({hs_i, vs_i, de_i}, 3)) else $error("timing outputs delay");
   a_pass_through:
   assert property ((ctrl_ff == 4'h0) [*4] |-> rgb_o == $past(rgb_i, 3)) else $error("pass through changed pixel");
   a_post_low_zero:
   assert property (ctrl_ff[3] [*4] |-> (rgb_o & 24'h030303) == 24'h0) else $error("post stage low bits active");
   a_pre_low_zero:
   assert property ((ctrl_ff == 4'h4) [*4] |-> (rgb_o & 24'h030303) == 24'h0) else $error("pre stage low bits active");
   a_dither_near:
   assert property ((ctrl_ff == 4'h8) [*4] |-> ok6(rgb_o[23:16], $past(rgb_i[23:16], 3))
      && ok6(rgb_o[15:8], $past(rgb_i[15:8], 3)) && ok6(rgb_o[7:0], $past(rgb_i[7:0], 3)))
      else $error("dither output off by more than one step");
endmodule // wb_dither_top_assertions

// ---- tb/wb_dither_top_test.sv ----
// self-checking bench for the white balance and dither block
`timescale 1ns/1ps
`include "wb_dither_consts.vh"
module wb_dither_top_test;
   reg clk_sys_i, resetn_i, psel, penable, pwrite; // clock, reset, bus controls
   reg [11:0] paddr; // bus address
   reg [31:0] pwdata, rdat; // write data, captured read data
   wire [31:0] prdata; // read data
   wire pready, pslverr, hs, vs, de, hs_o, vs_o, de_o; // bus answer and timing
   wire [23:0] rgb, rgb_o; // pixels in and out
   reg [23:0] pix, pix_fix, px; // source pixel, fixed pixel, random draw
   reg [23:0] in_d [0:2]; // input pixels delayed to match latency
   reg [7:0] lut [0:767]; // expected table contents, red green blue
   reg [3:0] mode; // control value in force
   reg rerr, chk_on, fix_on, cnt_go; // captured error, check and count gates
   integer seed, n_fail, cmp_count, i, c, cnt_n; // bookkeeping
   integer inc [0:2]; // dither increments counted per channel
   wb_dither_top u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .rgb_i(rgb), .hs_i(hs), .vs_i(vs), .de_i(de), .rgb_o(rgb_o), .hs_o(hs_o),
      .vs_o(vs_o), .de_o(de_o));
   video_src u_src (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .pix_i(pix), .rgb_o(rgb), .hs_o(hs),
      .vs_o(vs), .de_o(de));
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   task end_of_test;
      begin
         if (n_fail == 0 && cmp_count > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // one transfer, then an idle cycle so no signal is driven twice in a time step
   task apb(input reg wr, input reg [11:0] a, input reg [31:0] d);
      integer k;
      begin
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clk_sys_i);
         penable <= 1'b1;
         k = 0;
         @(posedge clk_sys_i);
         while (pready !== 1'b1 && k < 50) begin
            k = k + 1;
            @(posedge clk_sys_i);
         end
         if (k == 50) n_fail = n_fail + 1;
         rdat = prdata;
         rerr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk_sys_i);
      end
   endtask
   task rd_chk(input string nm, input [11:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         chk(nm, e, rdat);
      end
   endtask
   // pipeline refills under the new mode while checks are paused
   task set_mode(input [3:0] m);
      begin
         chk_on <= 1'b0;
         apb(1'b1, `OFS_CTRL, {28'h0, m});
         mode <= m;
         repeat (6) @(posedge clk_sys_i);
         chk_on <= 1'b1;
      end
   endtask
   // expected pixel: table lookup when on, then a one step band with quiet low bits when dithering
   task chk_pix(input [23:0] in, input [23:0] o);
      reg [7:0] b, v;
      reg ok;
      begin
         ok = 1'b1;
         for (c = 0; c < 3; c = c + 1) begin
            b = in[c*8 +: 8];
            if (mode[0]) b = lut[(2 - c) * 256 + b];
            v = o[c*8 +: 8];
            if (mode[3] || mode[2]) ok = ok && v[1:0] === 2'b00 && ({1'b0, v[7:2]} - {1'b0, b[7:2]}) <= 7'h01;
            else ok = ok && v === b;
         end
         cmp_count = cmp_count + 1;
         if (ok !== 1'b1) begin
            n_fail = n_fail + 1;
            $display("MISMATCH pixel expected %h seen %h", in, o);
         end
      end
   endtask
   // random pixels; red 05 is kept free for the reload scenario
   always @(posedge clk_sys_i) begin
      px = $random(seed);
      if (px[23:16] == 8'h05) px[23:16] = 8'h06;
      pix <= fix_on ? pix_fix : px;
      in_d[0] <= rgb;
      in_d[1] <= in_d[0];
      in_d[2] <= in_d[1];
      if (chk_on && de_o === 1'b1) chk_pix(in_d[2], rgb_o);
      if (cnt_go && cnt_n < 128 && de_o === 1'b1) begin
         cnt_n = cnt_n + 1;
         for (c = 0; c < 3; c = c + 1) if (rgb_o[c*8+2 +: 6] == 6'h21) inc[c] = inc[c] + 1;
      end
   end
   initial begin
      #(20 * 40000);
      n_fail = n_fail + 1;
      end_of_test;
   end
   initial begin
      seed = 9;
      {n_fail, cmp_count, cnt_n} = 0;
      {inc[0], inc[1], inc[2]} = 0;
      {resetn_i, psel, penable, pwrite, chk_on, fix_on, cnt_go} = 0;
      {paddr, pwdata, pix, pix_fix, mode} = 0;
      repeat (8) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_chk("ctrl", `OFS_CTRL, 32'h0);
      rd_chk("timing", `OFS_TIMING, {28'h0, `TIMING_RST});
      rd_chk("status", `OFS_STATUS, 32'h0);
      rd_chk("unmapped", 12'h018, 32'h0);
      chk("slverr", 32'h1, {31'h0, rerr});
      apb(1'b1, `OFS_TIMING, 32'hE);
      for (i = 0; i < 768; i = i + 1) begin
         if (i % 256 == 0) apb(1'b1, `OFS_PAGE, i / 256);
         lut[i] = $random(seed);
         apb(1'b1, `OFS_LUT_DATA, {24'h0, lut[i]});
      end
      rd_chk("status", `OFS_STATUS, 32'h7);
      for (i = 0; i < 3; i = i + 1) begin
         c = $random(seed) & 255;
         apb(1'b1, `OFS_PAGE, i);
         apb(1'b1, `OFS_LUT_ADDR, c);
         rd_chk("entry", `OFS_LUT_DATA, {24'h0, lut[i * 256 + c]});
      end
      for (i = 0; i < 5; i = i + 1) begin
         set_mode(20'h98410 >> (4 * i));
         repeat (150) @(posedge clk_sys_i);
      end
      pix_fix <= 24'h808080;
      fix_on <= 1'b1;
      set_mode(4'h8);
      cnt_go <= 1'b1;
      i = 0;
      while (cnt_n < 128 && i < 2000) begin
         i = i + 1;
         @(posedge clk_sys_i);
      end
      for (c = 0; c < 3; c = c + 1) chk("increments", 16, inc[c]);
      fix_on <= 1'b0;
      set_mode(4'h1);
      rd_chk("status", `OFS_STATUS, 32'h1F);
      apb(1'b1, `OFS_PAGE, 0);
      apb(1'b1, `OFS_LUT_ADDR, 5);
      apb(1'b1, `OFS_LUT_DATA, {24'h0, ~lut[5]});
      apb(1'b1, `OFS_LUT_ADDR, 5);
      rd_chk("locked entry", `OFS_LUT_DATA, {24'h0, lut[5]});
      set_mode(4'h3);
      apb(1'b1, `OFS_PAGE, 0);
      apb(1'b1, `OFS_LUT_ADDR, 5);
      lut[5] = ~lut[5] & 8'hFC;
      apb(1'b1, `OFS_LUT_DATA, {24'h0, lut[5]});
      pix_fix <= 24'h050505;
      fix_on <= 1'b1;
      repeat (150) @(posedge clk_sys_i);
      rd_chk("status", `OFS_STATUS, 32'h0F);
      end_of_test;
   end
endmodule // wb_dither_top_test
bind wb_dither_top wb_dither_top_assertions u_chk (.clk_sys_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rgb_i, .hs_i, .vs_i, .de_i, .rgb_o, .hs_o,
   .vs_o, .de_o);

// ---- verilog/frc_dither.v ----
// one adaptive temporal/spatial dither stage, 8 bits in, 6 bits out
`timescale 1ns/1ps
module frc_dither (
   input wire clk_sys_i,
   input wire resetn_i,
   input wire en_i,
   input wire [1:0] frame_i,
   input wire [1:0] line_i,
   input wire [2:0] pix_i,
   input wire [23:0] rgb_i,
   output reg [23:0] rgb_o
);
   // expand 8 bits to 9 so the full-scale value is reachable after rounding
   function [8:0] ext9;
      input [7:0] v;
      begin
         ext9 = {v, v[7]};
      end
   endfunction

   // default pattern for residue 001: three-bit cell, bit2 red, bit1 green, bit0 blue
   function [2:0] cell001;
      input [1:0] f;
      input [1:0] l;
      input [2:0] p;
      begin
         cell001 = 3'h0;
         case ({f, l})
            4'h0: cell001 = (p == 3'h0 || p == 3'h6) ? 3'h2 : 3'h0;
            4'h1: cell001 = (p == 3'h0 || p == 3'h4) ? 3'h5 : 3'h0;
            4'h2: cell001 = (p == 3'h2 || p == 3'h4) ? 3'h2 : 3'h0;
            4'h3: cell001 = (p == 3'h2 || p == 3'h6) ? 3'h5 : 3'h0;
            4'h5: cell001 = (p == 3'h1 || p == 3'h5) ? 3'h7 : 3'h0;
            4'h7: cell001 = (p == 3'h3 || p == 3'h7) ? 3'h7 : 3'h0;
            4'h8: cell001 = (p == 3'h2 || p == 3'h4) ? 3'h2 : 3'h0;
            4'h9: cell001 = (p == 3'h2 || p == 3'h6) ? 3'h5 : 3'h0;
            4'hA: cell001 = (p == 3'h0 || p == 3'h6) ? 3'h2 : 3'h0;
            4'hB: cell001 = (p == 3'h0 || p == 3'h4) ? 3'h5 : 3'h0;
            4'hD: cell001 = (p == 3'h3 || p == 3'h7) ? 3'h7 : 3'h0;
            4'hF: cell001 = (p == 3'h1 || p == 3'h5) ? 3'h7 : 3'h0;
            default: cell001 = 3'h0;
         endcase
      end
   endfunction

   // generic per-colour increment for residue r (0..7 of 8) over 4x4x8 cells
   function inc_generic;
      input [2:0] r;
      input [1:0] f;
      input [1:0] l;
      input [2:0] p;
      reg [2:0] rank;
      begin
         // ordered rank mixes position and frame so hits rotate every frame
         rank = {p[0] ^ l[0], l[1] ^ f[0], p[1] ^ f[1]} ^ {1'b0, p[2], 1'b0};
         inc_generic = (rank < r);
      end
   endfunction

   wire [8:0] ext_r = ext9(rgb_i[23:16]);
   wire [8:0] ext_g = ext9(rgb_i[15:8]);
   wire [8:0] ext_b = ext9(rgb_i[7:0]);
   wire [2:0] pat001 = cell001(frame_i, line_i, pix_i);
   // algorithm select: 0 default, 1 black/white pixel, 2 full-on subpixel, 3 full-off subpixel
   reg [1:0] alg;
   reg [2:0] inc;
   reg [23:0] out_c;
   reg [5:0] t;
   reg [2:0] res;
   integer c;

   // choose algorithm, then form the per-colour increment
   always @* begin
      alg = 2'h0;
      inc = 3'h0;
      out_c = 24'h000000;
      t = 6'h00;
      res = 3'h0;
      if (rgb_i == 24'h000000 || rgb_i == 24'hFFFFFF) begin
         alg = 2'h1;
      end else if (rgb_i[23:16] == 8'hFF || rgb_i[15:8] == 8'hFF || rgb_i[7:0] == 8'hFF) begin
         alg = 2'h2;
      end else if (rgb_i[23:16] == 8'h00 || rgb_i[15:8] == 8'h00 || rgb_i[7:0] == 8'h00) begin
         alg = 2'h3;
      end
      for (c = 0; c < 3; c = c + 1) begin
         case (c)
            0: res = ext_r[2:0];
            1: res = ext_g[2:0];
            default: res = ext_b[2:0];
         endcase
         case (c)
            0: t = ext_r[8:3];
            1: t = ext_g[8:3];
            default: t = ext_b[8:3];
         endcase
         // saturated subpixels never move, which keeps black and white flat
         if (alg == 2'h1 || t == 6'h3F || (alg == 2'h3 && t == 6'h00 && res == 3'h0)) begin
            inc[2 - c] = 1'b0;
         end else if (res == 3'h1) begin
            inc[2 - c] = pat001[2 - c];
         end else begin
            inc[2 - c] = inc_generic(res, frame_i, line_i, pix_i);
         end
         // increment the truncated value by the cell flag, low bits held inactive
         case (c)
            0: out_c[23:16] = {t + {5'h00, inc[2]}, 2'h0};
            1: out_c[15:8] = {t + {5'h00, inc[1]}, 2'h0};
            default: out_c[7:0] = {t + {5'h00, inc[0]}, 2'h0};
         endcase
      end
   end

   // register the result; a disabled stage passes the pixel with the same delay
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         rgb_o <= 24'h000000;
      end else if (en_i) begin
         rgb_o <= out_c;
      end else begin
         rgb_o <= rgb_i;
      end
   end
endmodule // frc_dither

// ---- verilog/wb_dither_top.v ----
// white balance lookup with pre and post dither stages behind an apb slave
`timescale 1ns/1ps
`include "wb_dither_consts.vh"
module wb_dither_top (
   input wire clk_sys_i,
   input wire resetn_i,
   // apb slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // video in from receive pipeline
   input wire [23:0] rgb_i,
   input wire hs_i,
   input wire vs_i,
   input wire de_i,
   // video out to the panel
   output wire [23:0] rgb_o,
   output reg hs_o,
   output reg vs_o,
   output reg de_o
);
   // decode an apb offset to a register hit
   function hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   reg [3:0] ctrl_ff; // control bits
   reg [3:0] timing_ff; // timing type and polarities
   reg [1:0] page_ff; // table selected for access
   reg [7:0] lut_addr_ff; // entry pointer, steps on each data read and each accepted data write
   reg wb_init_ff; // white balance has been turned on once
   reg [2:0] loaded_ff; // set once a write lands on entry 255 of a table, one bit each
   reg [31:0] prdata_ff; // read data register
   reg [7:0] lut_r [0:255]; // red table
   reg [7:0] lut_g [0:255]; // green table
   reg [7:0] lut_b [0:255]; // blue table

   wire access = psel_i & penable_i;
   wire wr = access & pwrite_i;
   wire mapped = hit(paddr_i, `OFS_CTRL) | hit(paddr_i, `OFS_TIMING) | hit(paddr_i, `OFS_PAGE) |
                 hit(paddr_i, `OFS_LUT_ADDR) | hit(paddr_i, `OFS_LUT_DATA) | hit(paddr_i, `OFS_STATUS);
   // a table write is refused once white balance ran, unless reload is allowed
   wire lut_locked = wb_init_ff & ~ctrl_ff[`CTRL_RELOAD_EN];
   wire lut_wr = wr & hit(paddr_i, `OFS_LUT_DATA) & ~lut_locked;

   // ready is immediate, one wait-free access phase per transfer
   assign pready_o = 1'b1;
   assign pslverr_o = access & ~mapped;
   assign prdata_o = prdata_ff;

   // control registers and the table pointer
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         ctrl_ff <= `CTRL_RST;
         timing_ff <= `TIMING_RST;
         page_ff <= `PAGE_RED;
         lut_addr_ff <= 8'h00;
         wb_init_ff <= 1'b0;
         loaded_ff <= 3'h0;
      end else begin
         if (wr && hit(paddr_i, `OFS_CTRL)) begin
            ctrl_ff <= pwdata_i[3:0];
         end
         if (wr && hit(paddr_i, `OFS_TIMING)) begin
            timing_ff <= pwdata_i[3:0];
         end
         if (wr && hit(paddr_i, `OFS_PAGE)) begin
            page_ff <= pwdata_i[1:0];
            lut_addr_ff <= 8'h00;
         end
         if (wr && hit(paddr_i, `OFS_LUT_ADDR)) begin
            lut_addr_ff <= pwdata_i[7:0];
         end
         // data accesses auto-step so a full table loads in 256 writes
         if (lut_wr || (access && !pwrite_i && hit(paddr_i, `OFS_LUT_DATA))) begin
            lut_addr_ff <= lut_addr_ff + 8'h01;
         end
         if (lut_wr && lut_addr_ff == 8'hFF && page_ff != 2'h3) begin
            loaded_ff[page_ff] <= 1'b1;
         end
         // sticky: the white balance flag persists until reset; reload enable lifts the lock
         if (ctrl_ff[`CTRL_WB_EN]) begin
            wb_init_ff <= 1'b1;
         end
      end
   end

   // table writes; each entry lands in the clock of its bus access, even mid-frame
   always @(posedge clk_sys_i) begin
      if (lut_wr) begin
         case (page_ff)
            `PAGE_RED: lut_r[lut_addr_ff] <= pwdata_i[7:0];
            `PAGE_GREEN: lut_g[lut_addr_ff] <= pwdata_i[7:0];
            `PAGE_BLUE: lut_b[lut_addr_ff] <= pwdata_i[7:0];
            default: ;
         endcase
      end
   end

   // read data is captured in setup so it is ready in the access phase
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         prdata_ff <= 32'h00000000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         case (paddr_i)
            `OFS_CTRL: prdata_ff <= {28'h0000000, ctrl_ff};
            `OFS_TIMING: prdata_ff <= {28'h0000000, timing_ff};
            `OFS_PAGE: prdata_ff <= {30'h00000000, page_ff};
            `OFS_LUT_ADDR: prdata_ff <= {24'h000000, lut_addr_ff};
            `OFS_LUT_DATA: begin
               case (page_ff)
                  `PAGE_RED: prdata_ff <= {24'h000000, lut_r[lut_addr_ff]};
                  `PAGE_GREEN: prdata_ff <= {24'h000000, lut_g[lut_addr_ff]};
                  `PAGE_BLUE: prdata_ff <= {24'h000000, lut_b[lut_addr_ff]};
                  default: prdata_ff <= 32'h00000000;
               endcase
            end
            `OFS_STATUS: prdata_ff <= {27'h0000000, lut_locked, wb_init_ff, loaded_ff};
            default: prdata_ff <= 32'h00000000;
         endcase
      end
   end

   // timing: normalise polarity, then find line and frame starts
   wire de_act = de_i ^ ~timing_ff[`TIM_DE_POL];
   wire hs_act = hs_i ^ ~timing_ff[`TIM_HS_POL];
   wire vs_act = vs_i ^ ~timing_ff[`TIM_VS_POL];
   reg de_d_ff;
   reg hs_d_ff;
   reg vs_d_ff;
   reg [11:0] blank_cnt_ff; // idle run length in de-only mode
   reg [1:0] frame_ff;
   reg [1:0] line_ff;
   reg [2:0] pix_ff;
   wire de_only = timing_ff[`TIM_DE_ONLY];
   wire line_start = de_only ? (de_act & ~de_d_ff) : (hs_act & ~hs_d_ff);
   // without vsync a long blank run marks the vertical boundary
   wire frame_start = de_only ? (de_act & ~de_d_ff & (blank_cnt_ff >= `DE_ONLY_BLANK)) : (vs_act & ~vs_d_ff);

   // frame, line and pixel indices for the dither patterns
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         de_d_ff <= 1'b0;
         hs_d_ff <= 1'b0;
         vs_d_ff <= 1'b0;
         blank_cnt_ff <= 12'h000;
         frame_ff <= 2'h0;
         line_ff <= 2'h0;
         pix_ff <= 3'h0;
      end else begin
         de_d_ff <= de_act;
         hs_d_ff <= hs_act;
         vs_d_ff <= vs_act;
         if (de_act) begin
            blank_cnt_ff <= 12'h000;
         end else if (blank_cnt_ff != 12'hFFF) begin
            blank_cnt_ff <= blank_cnt_ff + 12'h001;
         end
         if (frame_start) begin
            frame_ff <= frame_ff + 2'h1;
            line_ff <= 2'h0;
         end else if (line_start && de_only) begin
            line_ff <= line_ff + 2'h1;
         end else if (line_start) begin
            line_ff <= line_ff + 2'h1;
         end
         if (line_start || !de_act) begin
            pix_ff <= de_act ? 3'h1 : 3'h0;
         end else begin
            pix_ff <= pix_ff + 3'h1;
         end
      end
   end

   wire [2:0] pix_now = (line_start) ? 3'h0 : pix_ff;
   wire [23:0] pre_rgb;
   wire [23:0] post_rgb;
   reg [23:0] wb_rgb_ff; // lookup stage output
   reg [1:0] hs_p_ff; // sync delay line, two stages before the output flop
   reg [1:0] vs_p_ff;
   reg [1:0] de_p_ff;
   reg [1:0] frame_p_ff;
   reg [1:0] line_p_ff;
   reg [2:0] pix_p_ff;

   // stage 1: dither before the lookup
   frc_dither pre_lookup_dither (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .en_i(ctrl_ff[`CTRL_PRE_EN]),
      .frame_i(frame_ff),
      .line_i(line_ff),
      .pix_i(pix_now),
      .rgb_i(rgb_i),
      .rgb_o(pre_rgb)
   );

   // stage 2: lookup, or straight through with identical delay
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         wb_rgb_ff <= 24'h000000;
      end else if (ctrl_ff[`CTRL_WB_EN]) begin
         wb_rgb_ff <= {lut_r[pre_rgb[23:16]], lut_g[pre_rgb[15:8]], lut_b[pre_rgb[7:0]]};
      end else begin
         wb_rgb_ff <= pre_rgb;
      end
   end

   // pattern indices follow the pixel into the post stage
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         frame_p_ff <= 2'h0;
         line_p_ff <= 2'h0;
         pix_p_ff <= 3'h0;
      end else begin
         frame_p_ff <= frame_ff;
         line_p_ff <= line_ff;
         pix_p_ff <= pix_now;
      end
   end

   // stage 3: dither after the lookup; index skew of one pixel only shifts the pattern
   frc_dither post_lookup_dither (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .en_i(ctrl_ff[`CTRL_POST_EN]),
      .frame_i(frame_p_ff),
      .line_i(line_p_ff),
      .pix_i(pix_p_ff),
      .rgb_i(wb_rgb_ff),
      .rgb_o(post_rgb)
   );
   assign rgb_o = post_rgb;

   // sync outputs delayed three clocks to stay aligned with pixel data
   always @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         hs_p_ff <= 2'h0;
         vs_p_ff <= 2'h0;
         de_p_ff <= 2'h0;
         hs_o <= 1'b0;
         vs_o <= 1'b0;
         de_o <= 1'b0;
      end else begin
         hs_p_ff <= {hs_p_ff[0], hs_i};
         vs_p_ff <= {vs_p_ff[0], vs_i};
         de_p_ff <= {de_p_ff[0], de_i};
         hs_o <= hs_p_ff[1];
         vs_o <= vs_p_ff[1];
         de_o <= de_p_ff[1];
      end
   end
endmodule // wb_dither_top
